// ---- rtl/pll_powerup_pkg.sv ----
`default_nettype none
// ============================================================================
// Shared constants and carriers for the loop power-up control register.
package pll_powerup_pkg;

  // ==========================================================================
  // Bus geometry.
  localparam int unsigned ADDR_W = 4;   // Byte address bits decoded.
  localparam int unsigned DATA_W = 32;  // AXI4-Lite data width.
  localparam int unsigned REG_W  = 8;   // Width of the control register.

  // ==========================================================================
  // Register map (byte addresses).
  localparam logic [ADDR_W-1:0] PLL_POWERUP_CONTROL_ADDR = 4'h0;
  localparam logic [ADDR_W-1:0] PLL_CIRCUIT_STATUS_ADDR  = 4'h4;

  // ==========================================================================
  // Field positions inside the control register.
  localparam int unsigned RSVD_MSB                = 7;
  localparam int unsigned RSVD_LSB                = 5;
  localparam int unsigned LOOP_RESET_HOLD_BIT     = 4;
  localparam int unsigned OSC_BUFFER_POWERUP_BIT  = 3;
  localparam int unsigned OSCILLATOR_POWERUP_BIT  = 2;
  localparam int unsigned DIVIDER_POWERUP_BIT     = 1;
  localparam int unsigned CHARGE_PUMP_POWERUP_BIT = 0;

  // Field positions inside the status register.
  localparam int unsigned STAT_LOOP_RESET_BIT = 4;

  // ==========================================================================
  // Reset values.
  localparam logic [2:0] RSVD_VALUE            = 3'h7;
  localparam logic       LOOP_RESET_HOLD_RST   = 1'h1;
  localparam logic [3:0] POWERUP_RST           = 4'hf;

  // ==========================================================================
  // AXI response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // One bit for each loop circuit, in register bit order.
  typedef struct packed {
    logic osc_buffer;   // Oscillator buffer.
    logic oscillator;   // Oscillator.
    logic divider;      // Divider.
    logic charge_pump;  // Charge pump.
  } circuit_s;

  // Decoded state of one circuit.
  typedef enum logic [1:0] {
    CIRC_MODEM = 2'b00,  // Follows the modem block.
    CIRC_ON    = 2'b01,  // Forced on.
    CIRC_OFF   = 2'b10   // Forced off.
  } circ_mode_e;

endpackage : pll_powerup_pkg
`default_nettype wire

// ---- rtl/pll_powerup_control_reg.sv ----
// Added by the designer: the address map and the AXI4-Lite register port.
`default_nettype none
// ============================================================================
// Loop power-up control register with AXI4-Lite access and circuit decode.
//
// The bus slave answers a write one cycle after both halves are held and
// a read one cycle after its address is taken. The circuit enables and
// the loop reset are registered once more, so the analog side sees a
// register change one cycle after it lands.

// What this block does
// - Bits seven to five read 111, ignore writes.
// - Bit four holds loop in reset, 0 releases.
// - Bit three is oscillator buffer power-up control.
// - Bit two is oscillator power-up control.
// - Bit one is divider power-up, resets 1.
// - Bit zero is charge pump power-up, resets 1.
// - Pair decode: 11 modem, 01 off, else on.
module pll_powerup_control_reg (
  // Clock and reset.
  input  wire logic                                 aclk,
  input  wire logic                                 aresetn,
  // AXI4-Lite write address channel.
  input  wire logic [pll_powerup_pkg::ADDR_W-1:0]   awaddr,
  input  wire logic [2:0]                           awprot,
  input  wire logic                                 awvalid,
  output logic                                      awready,
  // AXI4-Lite write data channel.
  input  wire logic [pll_powerup_pkg::DATA_W-1:0]   wdata,
  input  wire logic [3:0]                           wstrb,
  input  wire logic                                 wvalid,
  output logic                                      wready,
  // AXI4-Lite write response channel.
  output logic [1:0]                                bresp,
  output logic                                      bvalid,
  input  wire logic                                 bready,
  // AXI4-Lite read address channel.
  input  wire logic [pll_powerup_pkg::ADDR_W-1:0]   araddr,
  input  wire logic [2:0]                           arprot,
  input  wire logic                                 arvalid,
  output logic                                      arready,
  // AXI4-Lite read data channel.
  output logic [pll_powerup_pkg::DATA_W-1:0]        rdata,
  output logic [1:0]                                rresp,
  output logic                                      rvalid,
  input  wire logic                                 rready,
  // Power-down bits from the companion register, same clock.
  input  wire pll_powerup_pkg::circuit_s            powerdown,
  // Power requests from the modem block, same clock.
  input  wire pll_powerup_pkg::circuit_s            modem_request,
  // Circuit enables and loop reset toward the analog section.
  output pll_powerup_pkg::circuit_s                 circuit_enable,
  output logic                                      loop_reset
);

  // ==========================================================================
  // State of the whole block as one packed struct.
  // Bus handshakes, stored fields and registered outputs all live here, so
  // a single register process covers every flip-flop of the block.
  typedef struct packed {
    logic                                 awready;      // Address slot free.
    logic                                 aw_full;      // Address held.
    logic [pll_powerup_pkg::ADDR_W-1:0]   aw_addr;      // Held address.
    logic                                 wready;       // Data slot free.
    logic                                 w_full;       // Data held.
    logic [pll_powerup_pkg::REG_W-1:0]    w_data;       // Held low byte.
    logic                                 w_strb0;      // Low lane enable.
    logic                                 bvalid;       // Response pending.
    logic [1:0]                           bresp;        // Write response.
    logic                                 arready;      // Read slot free.
    logic                                 rvalid;       // Read data pending.
    logic [pll_powerup_pkg::DATA_W-1:0]   rdata;        // Read data.
    logic [1:0]                           rresp;        // Read response.
    logic                                 loop_reset_hold; // Stored bit 4.
    pll_powerup_pkg::circuit_s            powerup;      // Stored bits 3..0.
    pll_powerup_pkg::circuit_s            enable;       // Decoded enables.
    logic                                 loop_reset;   // Loop reset out.
  } state_s;

  state_s st_r;   // Registered state.
  state_s st_nxt; // Next state.

  // ==========================================================================
  // Pair decode of one circuit: power-down bit first, power-up bit second.
  // Only the pair 0,1 forces a circuit off, so clearing a power-up bit on
  // its own can never remove power from a circuit.
  function automatic pll_powerup_pkg::circ_mode_e decode_pair(
    input logic pd,
    input logic pu
  );
    pll_powerup_pkg::circ_mode_e mode;
    mode = pll_powerup_pkg::CIRC_ON;
    case ({pd, pu})
      2'b11:   mode = pll_powerup_pkg::CIRC_MODEM;
      2'b01:   mode = pll_powerup_pkg::CIRC_OFF;
      2'b10:   mode = pll_powerup_pkg::CIRC_ON;
      2'b00:   mode = pll_powerup_pkg::CIRC_ON;
      default: mode = pll_powerup_pkg::CIRC_ON;
    endcase
    return mode;
  endfunction

  // Enable of one circuit from its pair and the modem request.
  // The request passes untouched only in the shared mode; the forced
  // modes ignore it completely.
  function automatic logic circuit_on(
    input logic pd,
    input logic pu,
    input logic req
  );
    logic on;
    on = 1'b1;
    case (decode_pair(pd, pu))
      pll_powerup_pkg::CIRC_MODEM: on = req;
      pll_powerup_pkg::CIRC_OFF:   on = 1'b0;
      pll_powerup_pkg::CIRC_ON:    on = 1'b1;
      default:                     on = 1'b1;
    endcase
    return on;
  endfunction

  // Read view of the control register; the reserved field always reads 111.
  // The reserved bits are rebuilt on every read instead of being stored,
  // so no write can disturb them and no flip-flops are spent on them.
  function automatic logic [pll_powerup_pkg::REG_W-1:0] ctrl_view(
    input state_s s
  );
    logic [pll_powerup_pkg::REG_W-1:0] v;
    v = '0;
    v[pll_powerup_pkg::RSVD_MSB:pll_powerup_pkg::RSVD_LSB] =
      pll_powerup_pkg::RSVD_VALUE;
    v[pll_powerup_pkg::LOOP_RESET_HOLD_BIT]     = s.loop_reset_hold;
    v[pll_powerup_pkg::OSC_BUFFER_POWERUP_BIT]  = s.powerup.osc_buffer;
    v[pll_powerup_pkg::OSCILLATOR_POWERUP_BIT]  = s.powerup.oscillator;
    v[pll_powerup_pkg::DIVIDER_POWERUP_BIT]     = s.powerup.divider;
    v[pll_powerup_pkg::CHARGE_PUMP_POWERUP_BIT] = s.powerup.charge_pump;
    return v;
  endfunction

  // Unused protection bits and upper data lanes carry no meaning here.
  // The reduction only consumes the ignored inputs; nothing reads it.
  logic unused_ok;
  assign unused_ok = ^{awprot, arprot, wstrb[3:1],
                       wdata[pll_powerup_pkg::DATA_W-1:pll_powerup_pkg::REG_W]};

  // ==========================================================================
  // Next-state logic: bus slave, register update and circuit decode.
  // Later assignments in this process override earlier ones, so order
  // matters: a write completion follows the retire of an old response,
  // and a new read follows the retire of old read data.
  always_comb begin
    logic write_fire;
    logic [pll_powerup_pkg::REG_W-1:0] wd;
    write_fire = 1'b0;
    wd         = '0;
    st_nxt     = st_r;

    // Write address is caught into its slot; the slot then refuses more.
    // A second address waits with awready low until the response rises.
    if (awvalid && st_r.awready) begin
      st_nxt.awready = 1'b0;
      st_nxt.aw_full = 1'b1;
      st_nxt.aw_addr = awaddr;
    end

    // Write data is caught independently, in either order.
    if (wvalid && st_r.wready) begin
      st_nxt.wready  = 1'b0;
      st_nxt.w_full  = 1'b1;
      st_nxt.w_data  = wdata[pll_powerup_pkg::REG_W-1:0];
      st_nxt.w_strb0 = wstrb[0];
    end

    // Retire a finished response before a new one may be raised.
    if (st_r.bvalid && bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // Both halves held and no response outstanding: perform the write.
    // Holding a new write back while bvalid stands keeps bresp stable
    // until the master has seen it.
    if (st_r.aw_full && st_r.w_full && !st_r.bvalid) begin
      write_fire     = 1'b1;
      st_nxt.aw_full = 1'b0;
      st_nxt.w_full  = 1'b0;
      st_nxt.awready = 1'b1;
      st_nxt.wready  = 1'b1;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = pll_powerup_pkg::RESP_OKAY;
    end

    // Register update; the status register is read-only, so writes to it
    // are acknowledged with OKAY and change nothing; unmapped holes answer SLVERR.
    // Only byte lane zero carries the control register; a write with that
    // lane off is acknowledged with OKAY and changes nothing.
    if (write_fire) begin
      wd = st_r.w_data;
      if (st_r.aw_addr[pll_powerup_pkg::ADDR_W-1:2] ==
          pll_powerup_pkg::PLL_POWERUP_CONTROL_ADDR[
            pll_powerup_pkg::ADDR_W-1:2]) begin
        if (st_r.w_strb0) begin
          // Reserved bits 7..5 are not stored at all.
          st_nxt.loop_reset_hold =
            wd[pll_powerup_pkg::LOOP_RESET_HOLD_BIT];
          st_nxt.powerup.osc_buffer =
            wd[pll_powerup_pkg::OSC_BUFFER_POWERUP_BIT];
          st_nxt.powerup.oscillator =
            wd[pll_powerup_pkg::OSCILLATOR_POWERUP_BIT];
          st_nxt.powerup.divider =
            wd[pll_powerup_pkg::DIVIDER_POWERUP_BIT];
          st_nxt.powerup.charge_pump =
            wd[pll_powerup_pkg::CHARGE_PUMP_POWERUP_BIT];
        end
      end else if (st_r.aw_addr[pll_powerup_pkg::ADDR_W-1:2] !=
                   pll_powerup_pkg::PLL_CIRCUIT_STATUS_ADDR[
                     pll_powerup_pkg::ADDR_W-1:2]) begin
        st_nxt.bresp = pll_powerup_pkg::RESP_SLVERR;
      end
    end

    // Read data leaves once the master has taken it.
    if (st_r.rvalid && rready) begin
      st_nxt.rvalid  = 1'b0;
      st_nxt.arready = 1'b1;
    end

    // Read request: answer in the next cycle from the current state.
    // Reads and writes run independently, so a read taken in the cycle of
    // a register write returns the value from before that write.
    if (arvalid && st_r.arready) begin
      st_nxt.arready = 1'b0;
      st_nxt.rvalid  = 1'b1;
      st_nxt.rdata   = '0;
      st_nxt.rresp   = pll_powerup_pkg::RESP_OKAY;
      case (araddr[pll_powerup_pkg::ADDR_W-1:2])
        pll_powerup_pkg::PLL_POWERUP_CONTROL_ADDR[
          pll_powerup_pkg::ADDR_W-1:2]: begin
          st_nxt.rdata[pll_powerup_pkg::REG_W-1:0] = ctrl_view(st_r);
        end
        pll_powerup_pkg::PLL_CIRCUIT_STATUS_ADDR[
          pll_powerup_pkg::ADDR_W-1:2]: begin
          // Live circuit state as driven toward the analog section.
          st_nxt.rdata[3:0] = st_r.enable;
          st_nxt.rdata[pll_powerup_pkg::STAT_LOOP_RESET_BIT] =
            st_r.loop_reset;
        end
        default: begin
          st_nxt.rresp = pll_powerup_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Decode each circuit from its pair and the modem request. The decode
    // is registered so the analog side never sees a combinational glitch.
    // The modem request comes from logic on this clock, so it needs no
    // synchroniser in front of the decode.
    st_nxt.enable.osc_buffer  = circuit_on(powerdown.osc_buffer,
      st_r.powerup.osc_buffer, modem_request.osc_buffer);
    st_nxt.enable.oscillator  = circuit_on(powerdown.oscillator,
      st_r.powerup.oscillator, modem_request.oscillator);
    st_nxt.enable.divider     = circuit_on(powerdown.divider,
      st_r.powerup.divider, modem_request.divider);
    st_nxt.enable.charge_pump = circuit_on(powerdown.charge_pump,
      st_r.powerup.charge_pump, modem_request.charge_pump);

    // The loop is held in reset while the hold bit is set.
    st_nxt.loop_reset = st_r.loop_reset_hold;
  end

  // ==========================================================================
  // State register with synchronous active-low reset.
  // Only constants are loaded in reset. The enables start off and come up
  // one cycle after release, once the decode of the reset state has been
  // registered; users must allow that cycle before relying on them.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r                 <= '0;
      st_r.awready         <= 1'b1;
      st_r.wready          <= 1'b1;
      st_r.arready         <= 1'b1;
      st_r.loop_reset_hold <= pll_powerup_pkg::LOOP_RESET_HOLD_RST;
      st_r.powerup         <= pll_powerup_pkg::POWERUP_RST;
      st_r.enable          <= '0;
      st_r.loop_reset      <= pll_powerup_pkg::LOOP_RESET_HOLD_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Outputs straight from state flip-flops.
  // No output passes through any logic after its flip-flop.
  assign awready        = st_r.awready;
  assign wready         = st_r.wready;
  assign bvalid         = st_r.bvalid;
  assign bresp          = st_r.bresp;
  assign arready        = st_r.arready;
  assign rvalid         = st_r.rvalid;
  assign rdata          = st_r.rdata;
  assign rresp          = st_r.rresp;
  assign circuit_enable = st_r.enable;
  assign loop_reset     = st_r.loop_reset;

endmodule // pll_powerup_control_reg
`default_nettype wire

// ---- tb/pll_powerup_chk.sv ----
`default_nettype none
// ======================================================================
// Port checker for the loop power-up control register.
module pll_powerup_chk (
  // Clock and reset.
  input wire logic                       aclk,
  input wire logic                       aresetn,
  // Bus handshakes.
  input wire logic [3:0]                 awaddr,
  input wire logic                       awvalid,
  input wire logic                       awready,
  input wire logic                       wvalid,
  input wire logic                       wready,
  input wire logic [1:0]                 bresp,
  input wire logic                       bvalid,
  input wire logic                       bready,
  input wire logic [3:0]                 araddr,
  input wire logic                       arvalid,
  input wire logic                       arready,
  input wire logic [31:0]                rdata,
  input wire logic [1:0]                 rresp,
  input wire logic                       rvalid,
  input wire logic                       rready,
  // Circuit side.
  input wire pll_powerup_pkg::circuit_s  powerdown,
  input wire pll_powerup_pkg::circuit_s  modem_request,
  input wire pll_powerup_pkg::circuit_s  circuit_enable,
  input wire logic                       loop_reset
);
  // All checks share one clock, so one default clocking serves.
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ======================================================================
  // Properties.
  property p_rst;
    $rose(aresetn) |-> loop_reset && !bvalid && !rvalid
      && circuit_enable == 4'h0;
  endproperty
  // A set power-down bit with a modem request always powers the circuit.
  // The antecedent needs a sampled high reset so that the edge that
  // releases reset does not judge enables still cleared by reset.
  property p_force;
    aresetn |=> (($past(powerdown) & $past(modem_request)
      & ~circuit_enable) == 4'h0);
  endproperty
  property p_ctrl_rd;
    arvalid && arready && araddr[3:2] == 2'h0 |=> rdata[31:5] == 27'h7;
  endproperty
  property p_rd_err;
    arvalid && arready && araddr[3:2] > 2'h1 |=> rresp == 2'h2
      && rdata == 32'h0;
  endproperty
  // Both halves are held one cycle before the response is raised.
  property p_wr_err;
    awvalid && awready && wvalid && wready && awaddr[3:2] > 2'h1
      |=> ##1 (bvalid && bresp == 2'h2);
  endproperty
  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
  endproperty
  property p_rd_ans;
    arvalid && arready |=> rvalid ##0 !arready;
  endproperty
  property p_ar_busy;
    rvalid |-> !arready;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  a_force: assert property (p_force) else $error("enable dropped");
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("top bits");
  a_rd_err: assert property (p_rd_err) else $error("bad read answer");
  a_wr_err: assert property (p_wr_err) else $error("bad write answer");
  a_b_hold: assert property (p_b_hold) else $error("write answer moved");
  a_r_hold: assert property (p_r_hold) else $error("read answer moved");
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  a_ar_busy: assert property (p_ar_busy) else $error("address ready");
  c_wr: cover property (awvalid && awready && wvalid && wready);
  c_rd_err: cover property (arvalid && arready && araddr[3:2] == 2'h3);
  c_force: cover property ((powerdown & modem_request) != 4'h0);
endmodule // pll_powerup_chk

bind pll_powerup_control_reg pll_powerup_chk u_chk (.aclk, .aresetn,
  .awaddr, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready,
  .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
  .powerdown, .modem_request, .circuit_enable, .loop_reset);
`default_nettype wire

// ---- tb/test_pll_powerup_control_reg.sv ----
`default_nettype none
// ======================================================================
// Self-checking bench for the loop power-up control register.
module test_pll_powerup_control_reg;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0] OK  = pll_powerup_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = pll_powerup_pkg::RESP_SLVERR;
  logic                      aclk, aresetn, awvalid, awready, wvalid;
  logic                      wready, bvalid, bready, arvalid, arready;
  logic                      rvalid, rready, loop_reset;
  logic [3:0]                awaddr, araddr, wstrb;
  logic [1:0]                bresp, rresp;
  logic [31:0]               wdata, rdata;
  pll_powerup_pkg::circuit_s powerdown, modem_request, circuit_enable;
  int                        miscompares, tests_run;
  // Protection inputs are ignored by the block, so they stay tied.
  pll_powerup_control_reg uut (.aclk, .aresetn, .awaddr, .awprot(3'h0),
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .powerdown, .modem_request, .circuit_enable,
    .loop_reset);
  // ======================================================================
  // Common tasks.
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Address and data halves are tracked apart; the slave may take either.
  task automatic wr(input logic [3:0] a, input logic [7:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    check("bresp", {30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp,
                    input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    check("rresp", {30'h0, rresp}, {30'h0, er});
    check("rdata", rdata, exp);
  endtask
  // ======================================================================
  // Scenarios.
  task automatic t_reset();
    rd(4'h0, 32'hff, OK);
    rd(4'h4, 32'h15, OK);
    $display("t_reset done");
  endtask
  // Clearing everything must leave the top bits set and free the loop.
  task automatic t_write();
    wr(4'h0, 8'h00, 4'h1, OK);
    rd(4'h0, 32'he0, OK);
    check("loop_reset", {31'h0, loop_reset}, 32'h0);
    check("enable", {28'h0, circuit_enable}, 32'hf);
    wr(4'h0, 8'hff, 4'h0, OK);
    wr(4'h4, 8'h00, 4'h1, OK);
    wr(4'h8, 8'hff, 4'h1, ERR);
    rd(4'h0, 32'he0, OK);
    rd(4'h4, 32'h0f, OK);
    rd(4'hc, 32'h0, ERR);
    wr(4'h0, 8'h1f, 4'h1, OK);
    rd(4'h0, 32'hff, OK);
    check("loop_reset", {31'h0, loop_reset}, 32'h1);
    $display("t_write done");
  endtask
  // Each bit position sees all four pairs with the request high and low.
  task automatic t_decode();
    logic [7:0] pd2, pu2;
    logic [3:0] m;
    for (int k = 0; k < 4; k++) begin
      pd2 = {2{4'b1100}} << k;
      pu2 = {2{4'b1010}} << k;
      powerdown <= pd2[7:4];
      modem_request <= 4'hf;
      wr(4'h0, {4'h1, pu2[7:4]}, 4'h1, OK);
      for (int j = 0; j < 2; j++) begin
        m = j ? 4'h0 : 4'hf;
        modem_request <= m;
        repeat (3) @(posedge aclk);
        check("enable", {28'h0, circuit_enable},
              {28'h0, ~pu2[7:4] | (pd2[7:4] & m)});
      end
    end
    $display("t_decode done");
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ======================================================================
  // Clock, watchdog and main sequence.
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // The tests need well under a thousand cycles; this leaves a wide margin.
  initial begin
    #20us;
    miscompares++;
    complete_run();
  end
  initial begin
    miscompares = 0;
    tests_run = 0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wstrb, wdata} = 44'h0;
    powerdown = 4'hf;
    modem_request = 4'h5;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_write();
    t_decode();
    complete_run();
  end
endmodule // test_pll_powerup_control_reg
`default_nettype wire
